// file: core/sfh_fifo.v
// Purpose: small byte fifo between command decode and output shifter
// Assumes: single clock, synchronous reset
// Notes: valid/ready on both sides, honest full and empty
`timescale 1ns/10ps
module sfh_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             i_clock,
    input  wire             i_rst,
    input  wire             i_flush,
    input  wire [WIDTH-1:0] i_data,
    input  wire             i_valid,
    output wire             o_ready,
    output wire [WIDTH-1:0] o_data,
    output wire             o_valid,
    input  wire             i_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_r;
    reg [AW:0]      rd_r;
    wire            empty;
    wire            full;
    wire            push;
    wire            pop;
    assign empty   = (wr_r == rd_r);
    assign full    = (wr_r[AW-1:0] == rd_r[AW-1:0]) && (wr_r[AW] != rd_r[AW]);
    assign o_ready = ~full;
    assign o_valid = ~empty;
    assign o_data  = mem[rd_r[AW-1:0]];
    assign push    = i_valid & ~full;
    assign pop     = i_ready & ~empty;
    // storage write
    always @(posedge i_clock) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= i_data;
        end
    end
    // pointers
    always @(posedge i_clock) begin
        if (i_rst || i_flush) begin
            wr_r <= {(AW+1){1'b0}};
            rd_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= rd_r + 1'b1;
            end
        end
    end
endmodule // sfh_fifo

// file: core/sfh_front.v
// Purpose: serial flash front end: pause handling and opcode decode
// Assumes: serial pins are asynchronous and sampled at 100 MHz
// Notes: memory array is outside; reads request bytes over a port
`timescale 1ns/10ps
`include "sfh_map.vh"
module sfh_front #(
    parameter [7:0]  MAKER_ID  = 8'h5A, // arbitrary value
    parameter [7:0]  PART_ID   = 8'h12, // arbitrary value
    parameter [7:0]  PART_ID2  = 8'h13, // arbitrary value
    parameter [15:0] BUSY_CYC  = `SFH_BUSY_CYC
) (
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire        i_cs_n,
    input  wire        i_sclk,
    input  wire        i_si,
    input  wire        i_hold_n,
    input  wire        i_wp_n,
    output reg         o_so,
    output wire        o_so_oe_n,
    output reg  [23:0] o_mem_addr,
    output wire        o_mem_req,
    input  wire [7:0]  i_mem_data,
    output reg         o_alter_go,
    output reg  [7:0]  o_alter_op,
    output reg  [23:0] o_alter_addr,
    output reg  [7:0]  o_alter_data,
    output reg         o_sleep,
    output reg  [7:0]  o_status
);
    localparam [3:0] S_OP    = 4'h0;
    localparam [3:0] S_ADDR  = 4'h1;
    localparam [3:0] S_DUMMY = 4'h2;
    localparam [3:0] S_STAT  = 4'h3;
    localparam [3:0] S_DATA  = 4'h4;
    localparam [3:0] S_WDATA = 4'h5;
    localparam [3:0] S_ID    = 4'h6;
    localparam [3:0] S_DEAD  = 4'h7;
    localparam [3:0] S_DONE  = 4'h8;

    wire cs_n_s;
    wire sclk_s;
    wire si_s;
    wire hold_n_s;
    wire wp_n_s;
    sfh_sync #(.RST_VAL(1'b1)) u_cs (.i_clock(i_clock), .i_rst(i_rst),
        .i_async(i_cs_n), .o_sync(cs_n_s));
    sfh_sync #(.RST_VAL(1'b0)) u_ck (.i_clock(i_clock), .i_rst(i_rst),
        .i_async(i_sclk), .o_sync(sclk_s));
    sfh_sync #(.RST_VAL(1'b0)) u_si (.i_clock(i_clock), .i_rst(i_rst),
        .i_async(i_si), .o_sync(si_s));
    sfh_sync #(.RST_VAL(1'b1)) u_hd (.i_clock(i_clock), .i_rst(i_rst),
        .i_async(i_hold_n), .o_sync(hold_n_s));
    sfh_sync #(.RST_VAL(1'b1)) u_wp (.i_clock(i_clock), .i_rst(i_rst),
        .i_async(i_wp_n), .o_sync(wp_n_s));

    reg        sclk_d_r;
    reg        cs_n_d_r;
    reg        paused_r;
    reg [3:0]  state_r;
    reg [7:0]  op_r;
    reg [7:0]  shin_r;
    reg [2:0]  bit_r;
    reg [1:0]  cnt_r;
    reg        wel_r;
    reg        busy_r;
    reg [15:0] busy_cnt_r;
    reg [2:0]  stat_hi_r;
    reg        srwd_r;
    reg        id_alt_r;
    reg [1:0]  id_idx_r;
    reg [7:0]  shout_r;
    reg [2:0]  obit_r;
    reg        out_en_r;
    reg        pend_r;
    reg        fill_r;

    wire       rise_raw;
    wire       fall_raw;
    wire       rise;
    wire       fall;
    wire       cs_up;
    wire [7:0] byte_in;
    wire       byte_done;
    wire       f_valid;
    wire [7:0] f_data;
    wire       f_ready;
    wire       f_in_ready;
    wire       f_pop;
    reg  [7:0] fill_data;

    assign rise_raw  = sclk_s & ~sclk_d_r;
    assign fall_raw  = ~sclk_s & sclk_d_r;
    assign rise      = rise_raw & ~paused_r & ~cs_n_s;
    assign fall      = fall_raw & ~paused_r & ~cs_n_s;
    assign cs_up     = cs_n_s & ~cs_n_d_r;
    assign byte_in   = {shin_r[6:0], si_s};
    assign byte_done = rise && (bit_r == 3'd7);
    assign o_so_oe_n = ~(out_en_r & ~paused_r & ~cs_n_s);
    // no fetch is taken in the deselect cycle that flushes the fifo
    assign o_mem_req = fill_r & f_in_ready & ~cs_n_s;
    assign f_pop     = fall & out_en_r & (obit_r == 3'd0);
    assign f_ready   = f_pop;

    // edge history
    always @(posedge i_clock) begin
        if (i_rst) begin
            sclk_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    // pause entry waits for clock low
    // pause exit waits for clock low
    always @(posedge i_clock) begin
        if (i_rst) begin
            paused_r <= 1'b0;
        end else if (cs_n_s) begin
            paused_r <= 1'b0;
        end else begin
            if (!sclk_s) begin
                paused_r <= ~hold_n_s;
            end
        end
    end

    // busy timer runs regardless of pause
    always @(posedge i_clock) begin
        if (i_rst) begin
            busy_r     <= 1'b0;
            busy_cnt_r <= 16'h0000;
        end else if (o_alter_go) begin
            busy_r     <= 1'b1;
            busy_cnt_r <= BUSY_CYC;
        end else if (busy_r) begin
            if (busy_cnt_r <= 16'h0001) begin
                busy_r <= 1'b0;
            end
            busy_cnt_r <= busy_cnt_r - 16'h0001;
        end
    end

    always @* begin
        o_status = {srwd_r, 2'b00, stat_hi_r, wel_r, busy_r};
    end

    // fifo fill selection: status byte, id bytes or array data
    always @* begin
        fill_data = i_mem_data;
        case (op_r)
            `SFH_OP_RDSTAT: fill_data = o_status;
            `SFH_OP_SIG:    fill_data = PART_ID;
            `SFH_OP_MAKERPART: fill_data = id_alt_r ? PART_ID : MAKER_ID;
            `SFH_OP_JEDEC: begin
                case (id_idx_r)
                    2'd0:    fill_data = MAKER_ID;
                    2'd1:    fill_data = PART_ID;
                    default: fill_data = PART_ID2;
                endcase
            end
            default: fill_data = i_mem_data;
        endcase
    end

    sfh_fifo #(.WIDTH(8), .DEPTH(`SFH_FIFO_DEPTH), .AW(`SFH_FIFO_AW)) u_fifo (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_flush (cs_n_s),
        .i_data  (fill_data),
        .i_valid (fill_r),
        .o_ready (f_in_ready),
        .o_data  (f_data),
        .o_valid (f_valid),
        .i_ready (f_ready)
    );

    always @(posedge i_clock) begin
        if (i_rst || cs_n_s) begin
            shout_r  <= 8'h00;
            obit_r   <= 3'd0;
            o_so     <= 1'b0;
        end else if (f_pop) begin
            o_so    <= f_valid ? f_data[7] : 1'b0;
            shout_r <= f_valid ? {f_data[6:0], 1'b0} : 8'h00;
            obit_r  <= 3'd7;
        end else if (fall && out_en_r) begin
            o_so    <= shout_r[7];
            shout_r <= {shout_r[6:0], 1'b0};
            obit_r  <= obit_r - 3'd1;
        end
    end

    // command decode and transaction state
    always @(posedge i_clock) begin
        o_alter_go <= 1'b0;
        if (i_rst) begin
            state_r      <= S_OP;
            op_r         <= 8'h00;
            shin_r       <= 8'h00;
            bit_r        <= 3'd0;
            cnt_r        <= 2'd0;
            wel_r        <= 1'b0;
            stat_hi_r    <= 3'b000;
            srwd_r       <= 1'b0;
            o_sleep      <= 1'b0;
            id_alt_r     <= 1'b0;
            id_idx_r     <= 2'd0;
            out_en_r     <= 1'b0;
            pend_r       <= 1'b0;
            fill_r       <= 1'b0;
            o_mem_addr   <= 24'h00_0000;
            o_alter_op   <= 8'h00;
            o_alter_addr <= 24'h00_0000;
            o_alter_data <= 8'h00;
        end else if (cs_n_s) begin
            if (cs_up && pend_r && bit_r == 3'd0) begin
                case (op_r)
                    `SFH_OP_WRITE_ENABLE_CMD: wel_r <= 1'b1;
                    `SFH_OP_WRITE_DISABLE_CMD: wel_r <= 1'b0;
                    `SFH_OP_SLEEP: o_sleep <= 1'b1;
                    default: begin
                        if (wel_r && !busy_r) begin
                            wel_r      <= 1'b0;
                            o_alter_go <= 1'b1;
                            // chip wipe has no address phase to latch it
                            o_alter_op <= op_r;
                            if (op_r == `SFH_OP_STATUS_WRITE_CMD &&
                                !(srwd_r && !wp_n_s)) begin
                                srwd_r    <= o_alter_data[7];
                                stat_hi_r <= o_alter_data[4:2];
                            end
                        end
                    end
                endcase
            end
            state_r  <= S_OP;
            bit_r    <= 3'd0;
            out_en_r <= 1'b0;
            pend_r   <= 1'b0;
            fill_r   <= 1'b0;
        end else begin
            if (fill_r && f_in_ready) begin
                id_alt_r   <= ~id_alt_r;
                id_idx_r   <= (id_idx_r == 2'd2) ? 2'd0 : id_idx_r + 2'd1;
                o_mem_addr <= o_mem_addr + 24'h00_0001;
            end
            if (rise) begin
                shin_r <= byte_in;
                bit_r  <= bit_r + 3'd1;
                if (bit_r != 3'd7) begin
                    pend_r <= pend_r & (state_r == S_DONE);
                end
            end
            if (byte_done) begin
                case (state_r)
                    S_OP: begin
                        op_r   <= byte_in;
                        cnt_r  <= 2'd0;
                        pend_r <= 1'b0;
                        state_r <= S_DEAD;
                        case (byte_in)
                            `SFH_OP_SLEEP, `SFH_OP_WRITE_ENABLE_CMD, `SFH_OP_WRITE_DISABLE_CMD,
                            `SFH_OP_CHIP_A, `SFH_OP_CHIP_B: begin
                                if (!o_sleep) begin
                                    pend_r  <= 1'b1;
                                    state_r <= S_DONE;
                                end
                            end
                            `SFH_OP_SIG: begin
                                o_sleep <= 1'b0;
                                state_r <= S_ADDR;
                            end
                            `SFH_OP_STATUS_WRITE_CMD: begin
                                if (!o_sleep) state_r <= S_WDATA;
                            end
                            `SFH_OP_RDSTAT: begin
                                if (!o_sleep) begin
                                    state_r  <= S_STAT;
                                    out_en_r <= 1'b1;
                                    fill_r   <= 1'b1;
                                end
                            end
                            `SFH_OP_JEDEC: begin
                                if (!o_sleep) begin
                                    id_idx_r <= 2'd0;
                                    state_r  <= S_ID;
                                    out_en_r <= 1'b1;
                                    fill_r   <= 1'b1;
                                end
                            end
                            `SFH_OP_MAKERPART, `SFH_OP_READ, `SFH_OP_FAST,
                            `SFH_OP_DUAL, `SFH_OP_SMALL, `SFH_OP_BIG_A,
                            `SFH_OP_BIG_B, `SFH_OP_PAGE: begin
                                if (!o_sleep) state_r <= S_ADDR;
                            end
                            default: state_r <= S_DEAD;
                        endcase
                    end
                    S_ADDR: begin
                        o_mem_addr <= {o_mem_addr[15:0], byte_in};
                        cnt_r      <= cnt_r + 2'd1;
                        if (cnt_r == 2'd2) begin
                            o_alter_op   <= op_r;
                            o_alter_addr <= {o_mem_addr[15:0], byte_in};
                            case (op_r)
                                `SFH_OP_READ: begin
                                    state_r  <= S_DATA;
                                    out_en_r <= 1'b1;
                                    fill_r   <= 1'b1;
                                end
                                `SFH_OP_FAST, `SFH_OP_DUAL:
                                    state_r <= S_DUMMY;
                                `SFH_OP_MAKERPART: begin
                                    id_alt_r <= (byte_in ==
                                        `SFH_ORDER_PART);
                                    state_r  <= S_ID;
                                    out_en_r <= 1'b1;
                                    fill_r   <= 1'b1;
                                end
                                `SFH_OP_SIG: begin
                                    state_r  <= S_ID;
                                    out_en_r <= 1'b1;
                                    fill_r   <= 1'b1;
                                end
                                `SFH_OP_PAGE: state_r <= S_WDATA;
                                default: begin
                                    pend_r  <= 1'b1;
                                    state_r <= S_DONE;
                                end
                            endcase
                        end
                    end
                    S_DUMMY: begin
                        state_r  <= S_DATA;
                        out_en_r <= 1'b1;
                        fill_r   <= 1'b1;
                    end
                    S_WDATA: begin
                        o_alter_data <= byte_in;
                        o_alter_op   <= op_r;
                        pend_r       <= 1'b1;
                        state_r      <= S_DONE;
                    end
                    S_DONE: pend_r <= 1'b0;
                    default: state_r <= state_r;
                endcase
            end
        end
    end
endmodule // sfh_front

// file: core/sfh_map.vh
// Purpose: constants for the serial flash hold and opcode decode front end
// Assumes: 100 MHz system clock, serial link sampled as plain inputs
// Notes: opcodes, status bit positions and timing counts
// Summary of operation
// - pause starts on pause pin falling, chip selected, serial clock low
// - pause ends on pause pin rising with serial clock low, else delayed
// - pause suspends the link only; busy operations run on to completion
// - while paused, output floats; data input and clock are ignored
// - chip select rising during pause resets the interface logic
// - opcode 05 streams the status byte until chip select rises
// - opcode B9 enters deep power-down
// - opcode AB wakes; after three filler bytes it streams the part byte
// - opcode 90, two fillers, order byte picks maker or part id first
// - inputs sampled on rising clock, outputs shifted on falling clock
// - altering and sleep commands need chip select rise on byte boundary
// - altering commands need the write enable latch; acceptance clears it
`ifndef SFH_MAP_VH
`define SFH_MAP_VH
`define SFH_OP_WRITE_ENABLE_CMD      8'h06
`define SFH_OP_WRITE_DISABLE_CMD      8'h04
`define SFH_OP_STATUS_WRITE_CMD      8'h01
`define SFH_OP_JEDEC     8'h9F
`define SFH_OP_RDSTAT    8'h05
`define SFH_OP_READ      8'h03
`define SFH_OP_FAST      8'h0B
`define SFH_OP_DUAL      8'h3B
`define SFH_OP_SIG       8'hAB
`define SFH_OP_MAKERPART 8'h90
`define SFH_OP_SMALL     8'h20
`define SFH_OP_BIG_A     8'h52
`define SFH_OP_BIG_B     8'hD8
`define SFH_OP_CHIP_A    8'h60
`define SFH_OP_CHIP_B    8'hC7
`define SFH_OP_PAGE      8'h02
`define SFH_OP_SLEEP     8'hB9
`define SFH_ORDER_MAKER  8'h00
`define SFH_ORDER_PART   8'h01
`define SFH_ST_BUSY      0
`define SFH_ST_WEL       1
`define SFH_FIFO_DEPTH   16
`define SFH_FIFO_AW      4
`define SFH_BUSY_NS      1000
`define SFH_CLK_NS       10
`define SFH_BUSY_CYC     ((`SFH_BUSY_NS + `SFH_CLK_NS - 1) / `SFH_CLK_NS)
`endif

// file: core/sfh_sync.v
// Purpose: two-stage synchroniser for one level from another domain
// Assumes: destination clock i_clock, synchronous reset
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module sfh_sync #(
    parameter RST_VAL = 1'b0
) (
    input  wire i_clock,
    input  wire i_rst,
    input  wire i_async,
    output wire o_sync
);
    reg meta_r;
    reg sync_r;
    // two flops in series
    always @(posedge i_clock) begin
        if (i_rst) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end
    assign o_sync = sync_r;
endmodule // sfh_sync

// file: testbench/sfh_front_asserts.sv
// Purpose: port checks for the flash hold and opcode front end
// Assumes: bound to sfh_front, serial clock period of 125 ns or more
// Notes: a few cycles of sync lag are allowed for
`timescale 1ns/10ps
module sfh_front_asserts #(
    parameter [15:0] BUSY_CYC = 16'h0005
) (
    input wire        i_clock,
    input wire        i_rst,
    input wire        i_cs_n,
    input wire        i_sclk,
    input wire        i_hold_n,
    input wire        o_so,
    input wire        o_so_oe_n,
    input wire [23:0] o_mem_addr,
    input wire        o_mem_req,
    input wire        o_alter_go,
    input wire        o_sleep,
    input wire [7:0]  o_status
);
    localparam int BMAX = BUSY_CYC + 10;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // chip deselected, link paused with clock low
    sequence idle_s; i_cs_n [*4]; endsequence
    sequence pause_s; (!i_hold_n && !i_sclk && !i_cs_n) [*5]; endsequence
    rst_vals_a: assert property (
        $past(i_rst) |-> o_so_oe_n && !o_sleep && o_status == 8'h00
        && !o_alter_go) else $error("reset value wrong");
    cs_float_a: assert property (
        idle_s |-> o_so_oe_n) else $error("output driven while idle");
    pause_float_a: assert property (
        pause_s |-> o_so_oe_n) else $error("output driven in pause");
    go_pulse_a: assert property (
        o_alter_go |=> !o_alter_go) else $error("go longer than a cycle");
    go_latch_a: assert property (
        o_alter_go |-> $past(o_status[1])) else $error("go without latch");
    go_busy_a: assert property (
        o_alter_go |-> ##[0:3] o_status[0]) else $error("busy not raised");
    busy_end_a: assert property (
        $rose(o_status[0]) |-> ##[1:BMAX] !o_status[0])
        else $error("busy never ends");
    wel_clear_a: assert property (
        $fell(o_status[0]) |-> !o_status[1]) else $error("latch kept");
    so_edge_a: assert property (
        !o_so_oe_n && $past(!o_so_oe_n) && $changed(o_so) |-> !$past(i_sclk))
        else $error("output moved with clock high");
    addr_inc_a: assert property (
        o_mem_req |=> o_mem_addr == $past(o_mem_addr) + 24'h00_0001)
        else $error("read address not incremented");
endmodule // sfh_front_asserts

bind sfh_front sfh_front_asserts #(.BUSY_CYC(BUSY_CYC)) chk_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
    .i_hold_n(i_hold_n), .o_so(o_so), .o_so_oe_n(o_so_oe_n),
    .o_mem_addr(o_mem_addr), .o_mem_req(o_mem_req),
    .o_alter_go(o_alter_go), .o_sleep(o_sleep), .o_status(o_status));

// file: testbench/sfh_host.sv
// Purpose: serial host controller model driving the flash pins
// Assumes: mode 0, clock parked low between frames
// Notes: a floated data line reads back inverted
`timescale 1ns/10ps
module sfh_host (
    input  wire  i_so,
    input  wire  i_so_oe_n,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_si,
    output logic o_hold_n
);
    localparam realtime HALF = 62.5;
    // pins idle at start
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_si = 1'b0;
        o_hold_n = 1'b1;
    end
    task automatic sel();
        o_hold_n = 1'b1;
        #(HALF) o_cs_n = 1'b0;
        #(HALF);
    endtask
    // released line toggles, not left at last bit
    task automatic desel();
        #(HALF) o_cs_n = 1'b1;
        o_si = ~o_si;
        #(HALF * 4);
    endtask
    // msb first, set low, taken at rise
    task automatic bits(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        for (int i = 7; i > 7 - n; i--) begin
            o_si = tx[i];
            #(HALF) o_sclk = 1'b1;
            rx = {rx[6:0], i_so_oe_n ? ~i_so : i_so};
            #(HALF) o_sclk = 1'b0;
        end
    endtask
    // pause pin moved only with clock low
    task automatic hold(input logic v);
        #(HALF) o_hold_n = v;
        #(HALF);
    endtask
endmodule // sfh_host

// file: testbench/tb_serial_flash_hold_and_opcode_decode.sv
// Purpose: self-checking bench for the flash hold and opcode front end
// Assumes: 100 MHz clock, 125 ns serial clock, busy shortened to 5
// Notes: array contents come from a fixed address hash
`timescale 1ns/10ps
module tb_serial_flash_hold_and_opcode_decode;
    localparam [7:0] MK = 8'hC3; // arbitrary value
    localparam [7:0] P1 = 8'h4E; // arbitrary value
    localparam [7:0] P2 = 8'h71; // arbitrary value
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        wp_n = 1'b1;
    wire         cs_n, sclk, si, hold_n, so, oe_n, go, slp, mreq;
    wire  [23:0] maddr, aaddr;
    wire  [7:0]  aop, adata, st, mdata;
    logic [7:0]  rxb, jk, sx;
    logic [23:0] gcnt = 24'h00_0000;
    logic [23:0] a;
    logic [7:0]  ops [7] = '{8'h01, 8'h02, 8'h20, 8'h52, 8'hD8, 8'h60,
                             8'hC7};
    logic [7:0]  rdo [3] = '{8'h03, 8'h0B, 8'h3B};
    logic [7:0]  idt [3] = '{MK, P1, P2};
    int          err_total = 0;
    int          compares = 0;
    always #5 clk = ~clk;
    // count accepted altering commands
    always @(posedge clk) if (go) gcnt <= gcnt + 24'h00_0001;
    function automatic logic [7:0] mf(input logic [23:0] x);
        return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h3C;
    endfunction
    assign mdata = mf(maddr);
    sfh_front #(.MAKER_ID(MK), .PART_ID(P1), .PART_ID2(P2),
                .BUSY_CYC(16'h0005)) dut_u (
        .i_clock(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sclk(sclk),
        .i_si(si), .i_hold_n(hold_n), .i_wp_n(wp_n), .o_so(so),
        .o_so_oe_n(oe_n), .o_mem_addr(maddr), .o_mem_req(mreq),
        .i_mem_data(mdata), .o_alter_go(go), .o_alter_op(aop),
        .o_alter_addr(aaddr), .o_alter_data(adata), .o_sleep(slp),
        .o_status(st));
    sfh_host h (.i_so(so), .i_so_oe_n(oe_n), .o_cs_n(cs_n),
                .o_sclk(sclk), .o_si(si), .o_hold_n(hold_n));
    task automatic chk(input string nm, input logic [23:0] s, e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic xb(input logic [7:0] t);
        h.bits(t, 8, rxb);
    endtask
    task automatic one(input logic [7:0] op);
        h.sel();
        xb(op);
        h.desel();
    endtask
    task automatic rd_st();
        h.sel();
        xb(8'h05);
        repeat (2) begin
            xb(8'($urandom));
            chk("status", rxb, sx);
        end
        h.desel();
    endtask
    task automatic alt(input logic [7:0] op, input logic en);
        logic [7:0]  d;
        logic [23:0] g;
        int          na;
        a = 24'($urandom);
        d = {1'($urandom), 7'h00};
        g = gcnt;
        na = (op == 8'h01 || op == 8'h60 || op == 8'hC7) ? 0 : 3;
        if (en)
            one(8'h06);
        h.sel();
        xb(op);
        for (int i = 0; i < na; i++)
            xb(a[23-8*i -: 8]);
        if (op == 8'h01 || op == 8'h02)
            xb(d);
        h.desel();
        chk("go", gcnt, g + en);
        if (en) begin
            chk("op", aop, op);
            if (na > 0)
                chk("addr", aaddr, a);
            if (op == 8'h01 || op == 8'h02)
                chk("data", adata, d);
            if (op == 8'h01)
                sx = d;
        end
        for (int i = 0; i < 300 && st[0] !== 1'b0; i++)
            @(negedge clk);
        rd_st();
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #(900_000);
        err_total++;
        test_done();
    end
    initial begin
        void'($urandom(54));
        sx = 8'h00;
        repeat (20) @(negedge clk);
        chk("st", st, 8'h00);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        rd_st();
        one(8'h06);
        sx[1] = 1'b1;
        rd_st();
        sx[1] = 1'b0;
        one(8'h04);
        rd_st();
        h.sel();
        xb(8'h06);
        h.bits(8'h00, 1, jk);
        h.desel();
        rd_st();
        alt(8'h20, 1'b0);
        foreach (ops[i])
            alt(ops[i], 1'b1);
        foreach (rdo[i]) begin
            a = 24'($urandom);
            h.sel();
            xb(rdo[i]);
            for (int k = 0; k < 3; k++)
                xb(a[23-8*k -: 8]);
            if (rdo[i] != 8'h03)
                xb(8'h00);
            for (int k = 0; k < 4; k++) begin
                xb(8'($urandom));
                chk("rd", rxb, mf(a + 24'(k)));
                if (k == 1) begin
                    h.hold(1'b0);
                    chk("oe", oe_n, 1'b1);
                    h.bits(8'($urandom), 8, jk);
                    h.hold(1'b1);
                end
            end
            h.desel();
        end
        h.sel();
        xb(8'h03);
        h.hold(1'b0);
        h.desel();
        chk("oe", oe_n, 1'b1);
        rd_st();
        h.sel();
        xb(8'h9F);
        for (int k = 0; k < 6; k++) begin
            xb(8'($urandom));
            chk("id", rxb, idt[k%3]);
        end
        h.desel();
        for (int o = 0; o < 2; o++) begin
            h.sel();
            xb(8'h90);
            xb(8'($urandom));
            xb(8'($urandom));
            xb(8'(o));
            for (int k = 0; k < 4; k++) begin
                xb(8'($urandom));
                chk("mp", rxb, ((k + o) % 2) ? P1 : MK);
            end
            h.desel();
        end
        h.sel();
        xb(8'hAB);
        repeat (3) xb(8'($urandom));
        repeat (2) begin
            xb(8'($urandom));
            chk("sig", rxb, P1);
        end
        h.desel();
        one(8'hB9);
        chk("slp", slp, 1'b1);
        h.sel();
        xb(8'h05);
        xb(8'h00);
        chk("oe", oe_n, 1'b1);
        h.desel();
        one(8'hAB);
        chk("slp", slp, 1'b0);
        h.sel();
        xb(8'hFF);
        xb(8'h00);
        chk("oe", oe_n, 1'b1);
        h.desel();
        test_done();
    end
endmodule // tb_serial_flash_hold_and_opcode_decode
